// *** logic/sensor_cfg_pkg.sv ***
// Purpose: Constants shared by the pin and readout configuration block.
// Assumes: Registers are 8 bits wide and addressed by an 8-bit serial index.
// Notes:   Reset values also serve as read values of unused bits.
package sensor_cfg_pkg;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] PIN_OVERRIDE_CTRL_IDX   = 8'h15;
  localparam logic [7:0] READOUT_OUTPUT_CTRL_IDX = 8'h16;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OVR_EN_BIT   = 0;
  localparam int OVR_QCLK_BIT = 1;
  localparam int OVR_FS_BIT   = 2;
  localparam int DRV_LO_BIT   = 3;
  localparam int DRV_HI_BIT   = 4;
  localparam int SYNC_SEL_BIT = 5;
  localparam int VSHUF_BIT    = 2;
  localparam int HMIR_BIT     = 3;
  localparam int VFLIP_BIT    = 4;
  localparam int STB_TS_BIT   = 5;
  localparam int QCLK_TS_BIT  = 6;
  localparam int PRESC_BIT    = 7;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] PIN_OVERRIDE_RST   = 8'h00;
  localparam logic [7:0] PIN_OVERRIDE_WMASK = 8'h3f;
  localparam logic [7:0] READOUT_RST        = 8'h01;
  localparam logic [7:0] READOUT_WMASK      = 8'hfc;
  localparam logic [7:0] UNMAPPED_RDATA     = 8'h00;
  // ----------------------------------------
  // Drive strength codes and prescaler
  // ----------------------------------------
  localparam logic [1:0] DRV_2MA  = 2'h0;
  localparam logic [1:0] DRV_4MA  = 2'h1;
  localparam logic [1:0] DRV_6MA  = 2'h2;
  localparam logic [1:0] PRESC_LAST = 2'h2;
  localparam int         TS_BITS  = 2;
endpackage

// *** logic/clk_prescaler.sv ***
// Purpose: Clock enable that keeps two of every three input clocks.
// Assumes: The clock generator advances only on cycles with the enable high.
// Notes:   With the divider off the enable is high on every cycle.
`timescale 1ns/10ps
module clk_prescaler
  import sensor_cfg_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic div_on,
  output logic      gen_clk_en
);
  logic [1:0] cnt_q, cnt_d;
  logic       en_q, en_d;

  always_comb begin
    cnt_d = cnt_q;
    en_d  = 1'b1;
    if (div_on) begin
      cnt_d = (cnt_q == PRESC_LAST) ? 2'h0 : cnt_q + 2'h1;
      en_d  = (cnt_d != PRESC_LAST);
    end else begin
      cnt_d = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      en_q  <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  assign gen_clk_en = en_q;

  property p_div_ratio;
    @(posedge clk) disable iff (rst)
      (div_on [*4]) ##0 !en_q |=> en_q ##1 en_q
        ##1 (!en_q || !$past(div_on) || !$past(div_on, 2));
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("prescaler ratio wrong");
endmodule

// *** logic/tristate_retimer.sv ***
// Purpose: Applies requested tri-state bits now or at the next field boundary.
// Assumes: field_boundary is a one-cycle pulse from the video timing.
// Notes:   The requested value stays readable while the applied one waits.
`timescale 1ns/10ps
module tristate_retimer #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         soft_clr,
  input  wire logic         retime_en,
  input  wire logic         field_boundary,
  input  wire logic [W-1:0] req,
  output logic      [W-1:0] applied
);
  logic [W-1:0] app_q, app_d;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      if (soft_clr) begin
        app_d[i] = 1'b0;
      end else if (!retime_en || field_boundary) begin
        app_d[i] = req[i];
      end else begin
        app_d[i] = app_q[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      app_q <= '0;
    end else begin
      app_q <= app_d;
    end
  end

  assign applied = app_q;

  property p_hold;
    @(posedge clk) disable iff (rst)
      retime_en && !field_boundary && !soft_clr |=> $stable(app_q);
  endproperty
  a_hold: assert property (p_hold) else $error("tri-state changed off boundary");
endmodule

// *** logic/sensor_pin_readout_config.sv ***
// Purpose: Pin override, drive, reset pin use, readout order and tri-state.
// Assumes: A serial engine presents register writes and reads as strobes.
// Notes:   All pins and strobes are synchronous to clk.
// How it works
// - Override enable drives qualifier clock and frame strobe from register bits.
// - Two-bit field picks 2, 4 or 6 mA; irrelevant while outputs disabled.
// - By default reset pin low resets serial registers and syncs timing.
// - Repurposed, reset pin high syncs timing and keeps serial registers.
// - Vertical shuffle reads even rows first, then odd rows.
// - Horizontal mirror reads columns in reverse order.
// - Vertical flip reads rows in reverse order.
// - Strobes are disabled by output-disable pin OR strobe tri-state bit.
// - Strobe tri-state reaches pins at field boundary when retime_en is set; reads show it at once.
// - Qualifier clock disabled by output-disable pin OR its own tri-state bit.
// - Qualifier clock tri-state may wait for a boundary; reads show it at once.
// - Prescaler bit divides the input clock by 1.5 before clock generation.
// - The retime_en input pin chooses boundary or immediate tri-state update.
`timescale 1ns/10ps
module sensor_pin_readout_config
  import sensor_cfg_pkg::*;
#(
  parameter int ROWS = 64,
  parameter int COLS = 64,
  parameter int RW   = $clog2(ROWS),
  parameter int CW   = $clog2(COLS)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  input  wire logic          system_reset_pin,
  input  wire logic          out_disable_pin,
  input  wire logic          retime_en,
  input  wire logic          field_boundary,
  input  wire logic          line_adv,
  input  wire logic          pixel_adv,
  input  wire logic          frame_strobe_in,
  input  wire logic          line_strobe_in,
  input  wire logic          qualifier_clock_in,
  output logic               frame_strobe,
  output logic               frame_strobe_oe_n,
  output logic               line_strobe,
  output logic               line_strobe_oe_n,
  output logic               qualifier_clock,
  output logic               qualifier_clock_oe_n,
  output logic      [1:0]    drive_strength,
  output logic               timing_sync,
  output logic               gen_clk_en,
  output logic      [RW-1:0] row_addr,
  output logic      [CW-1:0] col_addr
);
  import sensor_cfg_pkg::*;

  localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);
  localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);
  localparam logic [RW-1:0] EVEN_CNT = RW'((ROWS + 1) / 2);

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [7:0] pin_q, pin_d;
  logic [7:0] rdo_q, rdo_d;
  logic [7:0] rdata_q, rdata_d;
  logic       sync_q, sync_d;
  logic       sys_rst_act;
  logic       sync_in_act;

  always_comb begin
    sys_rst_act = !pin_q[SYNC_SEL_BIT] && !system_reset_pin;
    sync_in_act = pin_q[SYNC_SEL_BIT] && system_reset_pin;
    sync_d      = sys_rst_act || sync_in_act;
    pin_d       = pin_q;
    rdo_d       = rdo_q;
    rdata_d     = rdata_q;
    if (sys_rst_act) begin
      pin_d = PIN_OVERRIDE_RST;
      rdo_d = READOUT_RST;
    end else if (reg_wr) begin
      if (reg_addr == PIN_OVERRIDE_CTRL_IDX) begin
        pin_d = (reg_wdata & PIN_OVERRIDE_WMASK) |
                (PIN_OVERRIDE_RST & ~PIN_OVERRIDE_WMASK);
      end
      if (reg_addr == READOUT_OUTPUT_CTRL_IDX) begin
        rdo_d = (reg_wdata & READOUT_WMASK) |
                (READOUT_RST & ~READOUT_WMASK);
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        PIN_OVERRIDE_CTRL_IDX:   rdata_d = pin_q;
        READOUT_OUTPUT_CTRL_IDX: rdata_d = rdo_q;
        default:                 rdata_d = UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q   <= PIN_OVERRIDE_RST;
      rdo_q   <= READOUT_RST;
      rdata_q <= UNMAPPED_RDATA;
      sync_q  <= 1'b0;
    end else begin
      pin_q   <= pin_d;
      rdo_q   <= rdo_d;
      rdata_q <= rdata_d;
      sync_q  <= sync_d;
    end
  end

  // ----------------------------------------
  // Tri-state retiming and prescaler
  // ----------------------------------------
  logic [TS_BITS-1:0] ts_applied;

  tristate_retimer #(
    .W (TS_BITS)
  ) u_retimer (
    .clk            (clk),
    .rst            (rst),
    .soft_clr       (sys_rst_act),
    .retime_en      (retime_en),
    .field_boundary (field_boundary),
    .req            ({rdo_q[QCLK_TS_BIT], rdo_q[STB_TS_BIT]}),
    .applied        (ts_applied)
  );

  clk_prescaler u_presc (
    .clk        (clk),
    .rst        (rst),
    .div_on     (rdo_q[PRESC_BIT]),
    .gen_clk_en (gen_clk_en)
  );

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic       fs_q, fs_d;
  logic       ls_q, ls_d;
  logic       qc_q, qc_d;
  logic       fs_oen_q, fs_oen_d;
  logic       qc_oen_q, qc_oen_d;
  logic [1:0] drv_q, drv_d;

  always_comb begin
    if (pin_q[OVR_EN_BIT]) begin
      fs_d = pin_q[OVR_FS_BIT];
      qc_d = pin_q[OVR_QCLK_BIT];
    end else begin
      fs_d = frame_strobe_in;
      qc_d = qualifier_clock_in;
    end
    ls_d     = line_strobe_in;
    fs_oen_d = out_disable_pin || ts_applied[0];
    qc_oen_d = out_disable_pin || ts_applied[1];
    drv_d    = pin_q[DRV_HI_BIT:DRV_LO_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_q     <= 1'b0;
      ls_q     <= 1'b0;
      qc_q     <= 1'b0;
      fs_oen_q <= 1'b1;
      qc_oen_q <= 1'b1;
      drv_q    <= DRV_2MA;
    end else begin
      fs_q     <= fs_d;
      ls_q     <= ls_d;
      qc_q     <= qc_d;
      fs_oen_q <= fs_oen_d;
      qc_oen_q <= qc_oen_d;
      drv_q    <= drv_d;
    end
  end

  // ----------------------------------------
  // Readout address order
  // ----------------------------------------
  logic [RW-1:0] row_idx_q, row_idx_d;
  logic [CW-1:0] col_idx_q, col_idx_d;
  logic [RW-1:0] row_q, row_d;
  logic [CW-1:0] col_q, col_d;
  logic [RW-1:0] row_seq;

  always_comb begin
    row_idx_d = row_idx_q;
    col_idx_d = col_idx_q;
    if (sync_d || field_boundary) begin
      row_idx_d = '0;
      col_idx_d = '0;
    end else if (line_adv) begin
      row_idx_d = (row_idx_q == ROW_LAST) ? '0 : row_idx_q + 1'b1;
      col_idx_d = '0;
    end else if (pixel_adv) begin
      col_idx_d = (col_idx_q == COL_LAST) ? '0 : col_idx_q + 1'b1;
    end
    if (!rdo_q[VSHUF_BIT]) begin
      row_seq = row_idx_d;
    end else if (row_idx_d < EVEN_CNT) begin
      row_seq = RW'({row_idx_d, 1'b0});
    end else begin
      row_seq = RW'({row_idx_d - EVEN_CNT, 1'b1});
    end
    row_d = rdo_q[VFLIP_BIT] ? ROW_LAST - row_seq : row_seq;
    col_d = rdo_q[HMIR_BIT] ? COL_LAST - col_idx_d : col_idx_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_idx_q <= '0;
      col_idx_q <= '0;
      row_q     <= '0;
      col_q     <= '0;
    end else begin
      row_idx_q <= row_idx_d;
      col_idx_q <= col_idx_d;
      row_q     <= row_d;
      col_q     <= col_d;
    end
  end

  assign reg_rdata            = rdata_q;
  assign frame_strobe         = fs_q;
  assign frame_strobe_oe_n    = fs_oen_q;
  assign line_strobe          = ls_q;
  assign line_strobe_oe_n     = fs_oen_q;
  assign qualifier_clock      = qc_q;
  assign qualifier_clock_oe_n = qc_oen_q;
  assign drive_strength       = drv_q;
  assign timing_sync          = sync_q;
  assign row_addr             = row_q;
  assign col_addr             = col_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write(logic [7:0] idx);
    reg_wr && reg_addr == idx && !sys_rst_act;
  endsequence

  property p_override;
    pin_q[OVR_EN_BIT] |=> qualifier_clock == $past(pin_q[OVR_QCLK_BIT])
      && frame_strobe == $past(pin_q[OVR_FS_BIT]);
  endproperty
  a_override: assert property (p_override) else $error("override pins wrong");

  property p_drive;
    1'b1 |=> drive_strength == $past(pin_q[DRV_HI_BIT:DRV_LO_BIT]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive strength wrong");

  property p_sys_reset;
    !pin_q[SYNC_SEL_BIT] && !system_reset_pin |=> pin_q == PIN_OVERRIDE_RST
      && rdo_q == READOUT_RST && timing_sync;
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("pin reset failed");

  property p_sync_in;
    pin_q[SYNC_SEL_BIT] && system_reset_pin && !reg_wr |=> $stable(pin_q)
      && $stable(rdo_q) && timing_sync;
  endproperty
  a_sync_in: assert property (p_sync_in) else $error("sync input misbehaved");

  property p_flip;
    (sync_d || field_boundary) && rdo_q[VFLIP_BIT] && !rdo_q[VSHUF_BIT]
      |=> row_addr == ROW_LAST;
  endproperty
  a_flip: assert property (p_flip) else $error("vertical flip wrong");

  property p_shuffle;
    rdo_q[VSHUF_BIT] && !rdo_q[VFLIP_BIT] && !sync_d && !field_boundary
      && line_adv && row_idx_q == EVEN_CNT - 1'b1 |=> row_addr == RW'(1);
  endproperty
  a_shuffle: assert property (p_shuffle) else $error("shuffle order wrong");

  property p_mirror;
    (sync_d || field_boundary) && rdo_q[HMIR_BIT] |=> col_addr == COL_LAST;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror wrong");

  property p_strobe_oe;
    1'b1 |=> frame_strobe_oe_n == $past(out_disable_pin || ts_applied[0])
      && line_strobe_oe_n == frame_strobe_oe_n;
  endproperty
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe enable wrong");

  property p_qclk_oe;
    1'b1 |=> qualifier_clock_oe_n == $past(out_disable_pin || ts_applied[1]);
  endproperty
  a_qclk_oe: assert property (p_qclk_oe) else $error("qclk enable wrong");

  // A serial host leaves one idle cycle between a write and the next read.
  property p_readback;
    s_write(READOUT_OUTPUT_CTRL_IDX) ##1 (!reg_wr && !sys_rst_act) ##1 reg_rd
      && reg_addr == READOUT_OUTPUT_CTRL_IDX
      |=> reg_rdata == ($past(reg_wdata, 3) & READOUT_WMASK | READOUT_RST & ~READOUT_WMASK);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_immediate;
    !retime_en && !sys_rst_act |=> ts_applied == $past({rdo_q[QCLK_TS_BIT],
      rdo_q[STB_TS_BIT]});
  endproperty
  a_immediate: assert property (p_immediate) else $error("no immediate update");
endmodule

// *** verif/cfg_host.sv ***
// Purpose: Serial host model that writes and reads configuration bytes.
// Assumes: One byte per strobe; read data is settled the cycle after the strobe.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/10ps
module cfg_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ----------------------------------------
  // Byte transfers
  // ----------------------------------------
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// *** verif/sensor_pin_readout_config_tb.sv ***
// Purpose: Self-checking bench for the pin and readout configuration block.
// Assumes: Outputs settle within three cycles of the inputs or the write that cause them.
// Notes:   An eight by eight array keeps the readout order checks short.
`timescale 1ns/10ps
module sensor_pin_readout_config_tb;
  import sensor_cfg_pkg::*;
  typedef struct packed {
    logic [7:0] w15;
    logic [7:0] w16;
    logic [6:0] b;
  } row_s;
  // Field b holds disable, strobe in, qclk in, then strobe, qclk, strobe oe_n, qclk oe_n.
  row_s rows [6] = '{'{8'h00, 8'h01, 7'b010_1000}, '{8'h01, 8'h01, 7'b011_0000},
                     '{8'h07, 8'h01, 7'b000_1100}, '{8'h0f, 8'h21, 7'b001_1110},
                     '{8'h13, 8'h41, 7'b010_0101}, '{8'h19, 8'h01, 7'b111_0011}};
  logic [7:0] rmode [3] = '{8'h01, 8'h11, 8'h05};
  logic       clk = 1'b0;
  logic       rst, reg_wr, reg_rd, system_reset_pin, out_disable_pin, retime_en;
  logic       field_boundary, line_adv, pixel_adv, fs_in, ls_in, qc_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       fs, fs_oe_n, ls, ls_oe_n, qc, qc_oe_n, timing_sync, gen_clk_en;
  logic [1:0] drive_strength;
  logic [2:0] row_addr, col_addr, c, dc;
  int         n_errors, checks, cnt;

  always #4 clk = ~clk;

  cfg_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  sensor_pin_readout_config #(.ROWS(8), .COLS(8)) i_dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .system_reset_pin(system_reset_pin),
    .out_disable_pin(out_disable_pin), .retime_en(retime_en),
    .field_boundary(field_boundary), .line_adv(line_adv), .pixel_adv(pixel_adv),
    .frame_strobe_in(fs_in), .line_strobe_in(ls_in), .qualifier_clock_in(qc_in),
    .frame_strobe(fs), .frame_strobe_oe_n(fs_oe_n), .line_strobe(ls),
    .line_strobe_oe_n(ls_oe_n), .qualifier_clock(qc), .qualifier_clock_oe_n(qc_oe_n),
    .drive_strength(drive_strength), .timing_sync(timing_sync),
    .gen_clk_en(gen_clk_en), .row_addr(row_addr), .col_addr(col_addr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    field_boundary <= (k == 0);
    line_adv       <= (k == 1);
    pixel_adv      <= (k == 2);
    @(posedge clk);
    field_boundary <= 1'b0;
    line_adv       <= 1'b0;
    pixel_adv      <= 1'b0;
    cyc(3);
  endtask

  function automatic logic [2:0] exp_row(input int m, input int i);
    if (m == 0) return 3'(i);
    if (m == 1) return 3'(7 - i);
    return 3'((i < 4) ? 2 * i : 2 * i - 7);
  endfunction

  task automatic count_en(input int e);
    cnt = 0;
    repeat (30) begin
      cyc(1);
      cnt += int'(gen_clk_en);
    end
    chk(8'(cnt), 8'(e));
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, system_reset_pin} = 2'b11;
    {out_disable_pin, retime_en, field_boundary, line_adv, pixel_adv} = 5'h00;
    {fs_in, ls_in, qc_in} = 3'h0;
    cyc(10);
    chk1(fs_oe_n, 1'b1);
    rst <= 1'b0;
    cyc(2);
    foreach (rows[i]) begin
      out_disable_pin <= rows[i].b[6];
      fs_in           <= rows[i].b[5];
      ls_in           <= rows[i].b[5];
      qc_in           <= rows[i].b[4];
      i_host.wr(PIN_OVERRIDE_CTRL_IDX, rows[i].w15);
      i_host.wr(READOUT_OUTPUT_CTRL_IDX, rows[i].w16);
      cyc(3);
      if (!rows[i].b[1]) chk({6'h0, fs, ls}, {6'h0, rows[i].b[3], rows[i].b[5]});
      if (!rows[i].b[0]) chk1(qc, rows[i].b[2]);
      chk({5'h0, fs_oe_n, ls_oe_n, qc_oe_n}, {5'h0, rows[i].b[1], rows[i].b[1:0]});
      chk({6'h0, drive_strength}, {6'h0, rows[i].w15[4:3]});
    end
    $display("pin table done");
    out_disable_pin <= 1'b0;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    rdc(PIN_OVERRIDE_CTRL_IDX, 8'h00);
    rdc(READOUT_OUTPUT_CTRL_IDX, 8'h01);
    i_host.wr(PIN_OVERRIDE_CTRL_IDX, 8'hdf);
    i_host.wr(READOUT_OUTPUT_CTRL_IDX, 8'h7e);
    rdc(PIN_OVERRIDE_CTRL_IDX, 8'h1f);
    rdc(READOUT_OUTPUT_CTRL_IDX, 8'h7d);
    rdc(8'h17, 8'h00);
    system_reset_pin <= 1'b0;
    cyc(3);
    chk1(timing_sync, 1'b1);
    system_reset_pin <= 1'b1;
    cyc(3);
    chk1(timing_sync, 1'b0);
    rdc(PIN_OVERRIDE_CTRL_IDX, 8'h00);
    rdc(READOUT_OUTPUT_CTRL_IDX, 8'h01);
    i_host.wr(PIN_OVERRIDE_CTRL_IDX, 8'h20);
    system_reset_pin <= 1'b0;
    cyc(3);
    chk1(timing_sync, 1'b0);
    system_reset_pin <= 1'b1;
    cyc(3);
    chk1(timing_sync, 1'b1);
    rdc(PIN_OVERRIDE_CTRL_IDX, 8'h20);
    system_reset_pin <= 1'b0;
    i_host.wr(PIN_OVERRIDE_CTRL_IDX, 8'h00);
    cyc(2);
    system_reset_pin <= 1'b1;
    cyc(2);
    $display("reset pin done");
    retime_en <= 1'b1;
    i_host.wr(READOUT_OUTPUT_CTRL_IDX, 8'h61);
    rdc(READOUT_OUTPUT_CTRL_IDX, 8'h61);
    cyc(4);
    chk({6'h0, fs_oe_n, qc_oe_n}, 8'h00);
    pulse(0);
    chk({6'h0, fs_oe_n, qc_oe_n}, 8'h03);
    retime_en <= 1'b0;
    i_host.wr(READOUT_OUTPUT_CTRL_IDX, 8'h01);
    cyc(3);
    chk({6'h0, fs_oe_n, qc_oe_n}, 8'h00);
    $display("retime done");
    i_host.wr(READOUT_OUTPUT_CTRL_IDX, 8'h81);
    count_en(20);
    i_host.wr(READOUT_OUTPUT_CTRL_IDX, 8'h01);
    count_en(30);
    $display("prescaler done");
    foreach (rmode[m]) begin
      i_host.wr(READOUT_OUTPUT_CTRL_IDX, rmode[m]);
      pulse(0);
      for (int i = 0; i < 8; i++) begin
        chk({5'h0, row_addr}, {5'h0, exp_row(m, i)});
        pulse(1);
      end
    end
    for (int m = 0; m < 2; m++) begin
      i_host.wr(READOUT_OUTPUT_CTRL_IDX, (m == 1) ? 8'h09 : 8'h01);
      pulse(0);
      chk({5'h0, col_addr}, (m == 1) ? 8'h07 : 8'h00);
      pulse(2);
      c = col_addr;
      pulse(2);
      dc = (m == 1) ? c - col_addr : col_addr - c;
      chk({5'h0, dc}, 8'h01);
    end
    $display("readout order done");
    print_verdict();
  end
endmodule
